// ---- design/dtm_defines.svh ----
// Purpose: Offsets, field positions, reset values and divider counts of
//          the dual timer block.
// Assumes: APB with 32-bit data and byte addresses on paddr.
// Notes:   Definitions only; included by bare name.
`ifndef DTM_DEFINES_SVH
`define DTM_DEFINES_SVH

// Register byte offsets.
`define DTM_OFF_CTRL 8'h00
`define DTM_OFF_MODE 8'h04
`define DTM_OFF_T0LO 8'h08
`define DTM_OFF_T0HI 8'h0c
`define DTM_OFF_T1LO 8'h10
`define DTM_OFF_T1HI 8'h14
`define DTM_OFF_CSEL 8'h18
`define DTM_OFF_STAT 8'h1c
`define DTM_OFF_MASK 8'h20

// Reset values.
`define DTM_RST_CTRL 8'h00
`define DTM_RST_MODE 8'h00
`define DTM_RST_BYTE 8'h00
`define DTM_RST_CSEL 4'h0
`define DTM_RST_EVT 4'h0

// Clock-select register fields.
`define DTM_CSEL_SYS0 0
`define DTM_CSEL_SYS1 1
`define DTM_CSEL_SCA_LO 2
`define DTM_CSEL_SCA_HI 3

// Event bit positions in the status and mask registers.
`define DTM_EV_OVF0 0
`define DTM_EV_OVF1 1
`define DTM_EV_EXT0 2
`define DTM_EV_EXT1 3

// Prescaler terminal counts (divide by 12, 4, 48 and 8).
`define DTM_PRE_TC0 6'h0b
`define DTM_PRE_TC1 6'h03
`define DTM_PRE_TC2 6'h2f
`define DTM_PRE_TC3 6'h07

`endif

// ---- design/dtm_pkg.sv ----
// Purpose: Types shared by the dual timer block.
// Assumes: Bit layouts follow the control and mode register maps.
// Notes:   The step function gives one count step for a timer pair.
package dtm_pkg;

   typedef enum logic [1:0] {
      DTM_M13 = 2'h0,
      DTM_M16 = 2'h1,
      DTM_M8R = 2'h2,
      DTM_SPLIT = 2'h3
   } dtm_mode_t;

   // Control register layout, bit 7 first.
   typedef struct packed {
      logic ovf1;
      logic run1;
      logic ovf0;
      logic run0;
      logic xflag1;
      logic xtype1;
      logic xflag0;
      logic xtype0;
   } dtm_ctrl_t;

   // Mode register layout, bit 7 first.
   typedef struct packed {
      logic gate1;
      logic csel1;
      dtm_mode_t mode1;
      logic timer0_gate_enable;
      logic csel0;
      dtm_mode_t mode0;
   } dtm_mode_reg_t;

   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
      logic ovf;
   } dtm_step_t;

   function automatic dtm_step_t dtm_step(input dtm_mode_t m,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
      dtm_step_t s;
      s = '{lo: lo, hi: hi, ovf: 1'b0};
      unique case (m)
         DTM_M13: begin
            {s.hi, s.lo[4:0]} = {hi, lo[4:0]} + 13'h0001;
            s.ovf = (hi == 8'hff) && (lo[4:0] == 5'h1f);
         end
         DTM_M16: begin
            {s.hi, s.lo} = {hi, lo} + 16'h0001;
            s.ovf = (hi == 8'hff) && (lo == 8'hff);
         end
         DTM_M8R: begin
            s.ovf = (lo == 8'hff);
            s.lo = s.ovf ? hi : lo + 8'h01;
         end
         DTM_SPLIT: begin
            s.ovf = (lo == 8'hff);
            s.lo = lo + 8'h01;
         end
      endcase
      return s;
   endfunction : dtm_step

endpackage : dtm_pkg

// ---- design/dtm_dual_timer.sv ----
// Purpose: Two 8051-style counter/timers with their control register,
//          external interrupt flags and an APB register slave.
// Assumes: All pins are synchronous to pclk; zero-wait APB slave.
// Notes:   Counter registers are written by software with priority over
//          a count step in the same cycle.
//
// Behaviour
// R1: Sixteen-bit mode counts over the whole high and low byte pair.
// R2: Auto-reload: low byte wraps, sets overflow flag, reloads from high byte.
// R3: Auto-reload leaves the high byte unchanged; only software writes it.
// R4: Software loads the low byte before enabling an auto-reload timer.
// R5: An overflow flag set in auto-reload mode raises its interrupt request.
// R6: Timer 1 auto-reload behaves exactly like timer 0 with its own bits.
// R7: Split mode: timer 0 low byte uses timer 0 controls and flag.
// R8: Split low byte counts system timebase or external falling edges.
// R9: Split high byte counts internal clocks only, gated by timer 1 run.
// R10: Split high byte overflow sets timer 1 flag and its request.
// R11: During split, timer 1 counts no edges and sets no flag.
// R12: During split, timer 1 overflow pulse still reaches baud and converter.
// R13: During split, timer 1 runs in modes 0 to 2, stops in mode 3.
// R14: Timer 1 in mode 3 is inactive and holds its count.
// R15: Count only when run is set and gate clear or gate input high.
// R16: Setting run neither clears nor loads the counter.
// R17: Counter input falling edges are sampled on the system clock.
// R18: Overflow flags set on overflow, cleared by writing zero or vectoring.
// R19: External type selects level or falling edge; edge flags clear on vector.
`timescale 1ns/100ps
`include "dtm_defines.svh"

module dtm_dual_timer
   import dtm_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic count_input_pin_zero,
   input wire logic count_input_pin_one,
   input wire logic external_gate_input_zero,
   input wire logic external_gate_input_one,
   // Vectoring acknowledges from the interrupt controller
   input wire logic vector_ack_timer0,
   input wire logic vector_ack_timer1,
   input wire logic vector_ack_ext0,
   input wire logic vector_ack_ext1,
   // Requests and events
   output logic timer0_irq_req,
   output logic timer1_irq_req,
   output logic ext0_irq_req,
   output logic ext1_irq_req,
   output logic timer1_overflow_pulse,
   output logic irq
);

   dtm_mode_reg_t mode_q;
   logic [7:0] timer0_low_byte_q, timer0_high_byte_q;
   logic [7:0] timer1_low_byte_q, timer1_high_byte_q;
   logic timer0_run_bit_q, timer1_run_bit_q;
   logic [1:0] ovf_flag_q, ovf_set;
   logic [1:0] xtype_q, xflag_q, xset, xpin, xpin_q, xack;
   logic [1:0] cnt_pin_q, cnt_fall;
   logic [3:0] csel_q, stat_q, mask_q, events;
   logic [5:0] pre_q, pre_tc;
   logic pre_tick;
   logic [31:0] prdata_q, rdata;
   logic pslverr_q, rmapped, split, ovf1_pulse_q;
   logic wr, wr_ctrl;
   dtm_ctrl_t wctrl, ctrl_view;
   logic tick_external_gate_input_zero, tick_external_gate_input_one, tick0, tick1, run0, run1;
   logic cnt0_en, cnt1_en, hi_en, ovf_hi, ovf1_raw;
   dtm_step_t step0, step1;

   // Bus decode; every access completes with no wait state.
   assign pready = 1'b1;
   assign wr = psel && penable && pwrite;
   assign wr_ctrl = wr && (paddr == `DTM_OFF_CTRL);
   assign wctrl = dtm_ctrl_t'(pwdata[7:0]);

   // Prescaled clock shared by both timers.
   always_comb begin
      unique case (csel_q[`DTM_CSEL_SCA_HI:`DTM_CSEL_SCA_LO])
         2'h0: pre_tc = `DTM_PRE_TC0;
         2'h1: pre_tc = `DTM_PRE_TC1;
         2'h2: pre_tc = `DTM_PRE_TC2;
         2'h3: pre_tc = `DTM_PRE_TC3;
      endcase
   end
   assign pre_tick = (pre_q >= pre_tc);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 6'h00;
      end else if (pre_tick) begin
         pre_q <= 6'h00;
      end else begin
         pre_q <= pre_q + 6'h01;
      end
   end

   // Pin edge detection, one copy per channel.
   assign xpin = {external_gate_input_one, external_gate_input_zero};
   assign xack = {vector_ack_ext1, vector_ack_ext0};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         logic cpin;
         assign cpin = g ? count_input_pin_one : count_input_pin_zero;
         // A level must hold one clock so both samples see it.
         assign cnt_fall[g] = cnt_pin_q[g] && !cpin; // R17
         // Level mode raises an event when the flag first goes high.
         assign xset[g] = xtype_q[g] ? (xpin_q[g] && !xpin[g])
                                     : (!xpin[g] && !xflag_q[g]);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_pin_q[g] <= 1'b1;
               xpin_q[g] <= 1'b1;
            end else begin
               cnt_pin_q[g] <= cpin;
               xpin_q[g] <= xpin[g];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               xflag_q[g] <= 1'b0;
            end else if (!xtype_q[g]) begin
               xflag_q[g] <= !xpin[g]; // R19
            end else if (xset[g]) begin
               xflag_q[g] <= 1'b1; // R19
            end else if (xack[g]) begin
               xflag_q[g] <= 1'b0; // R19
            end else if (wr_ctrl) begin
               xflag_q[g] <= g ? wctrl.xflag1 : wctrl.xflag0;
            end
         end
      end
   endgenerate

   // Count enables and timebases.
   assign split = (mode_q.mode0 == DTM_SPLIT);
   assign tick_external_gate_input_zero = csel_q[`DTM_CSEL_SYS0] || pre_tick;
   assign tick_external_gate_input_one = csel_q[`DTM_CSEL_SYS1] || pre_tick;
   assign tick0 = mode_q.csel0 ? cnt_fall[0] : tick_external_gate_input_zero; // R8
   assign tick1 = (mode_q.csel1 && !split) ? cnt_fall[1] : tick_external_gate_input_one; // R11
   assign run0 = timer0_run_bit_q
              && (!mode_q.timer0_gate_enable || external_gate_input_zero); // R15 R7
   // Split mode hands timer 1 run control to its mode field alone.
   assign run1 = split ? (mode_q.mode1 != DTM_SPLIT) // R13
                       : (timer1_run_bit_q && (mode_q.mode1 != DTM_SPLIT)
                          && (!mode_q.gate1 || external_gate_input_one));
   assign cnt0_en = run0 && tick0;
   assign cnt1_en = run1 && tick1; // R14
   assign hi_en = split && timer1_run_bit_q && tick_external_gate_input_zero; // R9
   assign ovf_hi = hi_en && (timer0_high_byte_q == 8'hff);

   always_comb begin
      step0 = dtm_step(mode_q.mode0, timer0_low_byte_q, timer0_high_byte_q);
      step1 = dtm_step(mode_q.mode1, timer1_low_byte_q, timer1_high_byte_q);
   end

   assign ovf1_raw = cnt1_en && step1.ovf;
   assign ovf_set[0] = cnt0_en && step0.ovf; // R2 R7
   assign ovf_set[1] = split ? ovf_hi : ovf1_raw; // R10 R11 R6

   // Timer 0 byte pair; run changes never touch the counts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer0_low_byte_q <= `DTM_RST_BYTE;
      end else if (wr && paddr == `DTM_OFF_T0LO) begin
         timer0_low_byte_q <= pwdata[7:0];
      end else if (cnt0_en) begin
         timer0_low_byte_q <= step0.lo; // R1 R2 R7 R16
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer0_high_byte_q <= `DTM_RST_BYTE;
      end else if (wr && paddr == `DTM_OFF_T0HI) begin
         timer0_high_byte_q <= pwdata[7:0];
      end else if (hi_en) begin
         timer0_high_byte_q <= timer0_high_byte_q + 8'h01; // R9
      end else if (cnt0_en && !split) begin
         timer0_high_byte_q <= step0.hi; // R1 R3
      end
   end

   // Timer 1 byte pair.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer1_low_byte_q <= `DTM_RST_BYTE;
      end else if (wr && paddr == `DTM_OFF_T1LO) begin
         timer1_low_byte_q <= pwdata[7:0];
      end else if (cnt1_en) begin
         timer1_low_byte_q <= step1.lo; // R6 R1
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer1_high_byte_q <= `DTM_RST_BYTE;
      end else if (wr && paddr == `DTM_OFF_T1HI) begin
         timer1_high_byte_q <= pwdata[7:0];
      end else if (cnt1_en) begin
         timer1_high_byte_q <= step1.hi; // R6 R3
      end
   end

   // Overflow pulse to the baud-rate and converter-start logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf1_pulse_q <= 1'b0;
      end else begin
         ovf1_pulse_q <= ovf1_raw; // R12
      end
   end

   // Control register: run bits, types and overflow flags.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer0_run_bit_q <= 1'b0;
         timer1_run_bit_q <= 1'b0;
         xtype_q <= 2'h0;
      end else if (wr_ctrl) begin
         timer0_run_bit_q <= wctrl.run0; // R16
         timer1_run_bit_q <= wctrl.run1;
         xtype_q <= {wctrl.xtype1, wctrl.xtype0};
      end
   end

   // A hardware set beats a software clear or a vectoring clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_flag_q <= 2'h0;
      end else begin
         if (ovf_set[0]) begin
            ovf_flag_q[0] <= 1'b1; // R18
         end else if (vector_ack_timer0) begin
            ovf_flag_q[0] <= 1'b0; // R18
         end else if (wr_ctrl) begin
            ovf_flag_q[0] <= wctrl.ovf0; // R18
         end
         if (ovf_set[1]) begin
            ovf_flag_q[1] <= 1'b1; // R18
         end else if (vector_ack_timer1) begin
            ovf_flag_q[1] <= 1'b0; // R18
         end else if (wr_ctrl) begin
            ovf_flag_q[1] <= wctrl.ovf1; // R18
         end
      end
   end

   // Mode and clock-select registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= dtm_mode_reg_t'(`DTM_RST_MODE);
      end else if (wr && paddr == `DTM_OFF_MODE) begin
         mode_q <= dtm_mode_reg_t'(pwdata[7:0]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csel_q <= `DTM_RST_CSEL;
         mask_q <= `DTM_RST_EVT;
      end else begin
         if (wr && paddr == `DTM_OFF_CSEL) begin
            csel_q <= pwdata[3:0];
         end
         if (wr && paddr == `DTM_OFF_MASK) begin
            mask_q <= pwdata[3:0];
         end
      end
   end

   // Sticky event status, write one to clear; a new event wins.
   always_comb begin
      events = 4'h0;
      events[`DTM_EV_OVF0] = ovf_set[0];
      events[`DTM_EV_OVF1] = ovf_set[1];
      events[`DTM_EV_EXT0] = xset[0];
      events[`DTM_EV_EXT1] = xset[1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= `DTM_RST_EVT;
      end else if (wr && paddr == `DTM_OFF_STAT) begin
         stat_q <= (stat_q & ~pwdata[3:0]) | events;
      end else begin
         stat_q <= stat_q | events;
      end
   end

   // Read data is captured in the setup phase for a registered answer.
   always_comb begin
      ctrl_view = '{ovf1: ovf_flag_q[1], run1: timer1_run_bit_q,
                    ovf0: ovf_flag_q[0], run0: timer0_run_bit_q,
                    xflag1: xflag_q[1], xtype1: xtype_q[1],
                    xflag0: xflag_q[0], xtype0: xtype_q[0]};
      rdata = 32'h0000_0000;
      rmapped = 1'b1;
      unique case (paddr)
         `DTM_OFF_CTRL: rdata[7:0] = ctrl_view;
         `DTM_OFF_MODE: rdata[7:0] = mode_q;
         `DTM_OFF_T0LO: rdata[7:0] = timer0_low_byte_q;
         `DTM_OFF_T0HI: rdata[7:0] = timer0_high_byte_q;
         `DTM_OFF_T1LO: rdata[7:0] = timer1_low_byte_q;
         `DTM_OFF_T1HI: rdata[7:0] = timer1_high_byte_q;
         `DTM_OFF_CSEL: rdata[3:0] = csel_q;
         `DTM_OFF_STAT: rdata[3:0] = stat_q;
         `DTM_OFF_MASK: rdata[3:0] = mask_q;
         default: rmapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rdata;
         pslverr_q <= !rmapped;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // Requests follow the flags; the controller applies its own enables.
   assign timer0_irq_req = ovf_flag_q[0]; // R5
   assign timer1_irq_req = ovf_flag_q[1]; // R5 R10
   assign ext0_irq_req = xflag_q[0];
   assign ext1_irq_req = xflag_q[1];
   assign timer1_overflow_pulse = ovf1_pulse_q;
   assign irq = |(stat_q & mask_q);

endmodule : dtm_dual_timer

// ---- dv/dtm_chk.sv ----
// Purpose: Port-level checker for the dual timer.
// Assumes: Zero-wait APB slave with nine mapped words.
// Notes: Attached to every instance by bind.
`timescale 1ns/100ps
module dtm_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and events
   input wire logic external_gate_input_zero,
   input wire logic vector_ack_timer0,
   input wire logic vector_ack_timer1,
   input wire logic vector_ack_ext0,
   input wire logic timer0_irq_req,
   input wire logic timer1_irq_req,
   input wire logic ext0_irq_req,
   input wire logic ext1_irq_req,
   input wire logic timer1_overflow_pulse,
   input wire logic irq
);
   logic wr_acc;
   logic setup;
   logic reqs;
   assign wr_acc = psel && penable && pwrite;
   assign setup = psel && !penable;
   assign reqs = timer0_irq_req || timer1_irq_req || ext0_irq_req ||
      ext1_irq_req;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_err_unmapped;
      setup && !pwrite && paddr > 8'h20 |=> pslverr && prdata == 32'h0;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped)
      else $error("unmapped read not refused");
   property p_err_mapped;
      setup && paddr <= 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr;
   endproperty
   a_err_mapped: assert property (p_err_mapped)
      else $error("mapped access flagged");
   property p_rd_stable;
      $changed(prdata) |-> $past(setup);
   endproperty
   a_rd_stable: assert property (p_rd_stable)
      else $error("read data moved outside setup");
   property p_t0_fall;
      $fell(timer0_irq_req) |-> $past(vector_ack_timer0 || wr_acc);
   endproperty
   a_t0_fall: assert property (p_t0_fall)
      else $error("timer 0 flag dropped without cause");
   property p_t1_fall;
      $fell(timer1_irq_req) |-> $past(vector_ack_timer1 || wr_acc);
   endproperty
   a_t1_fall: assert property (p_t1_fall)
      else $error("timer 1 flag dropped without cause");
   property p_e0_fall;
      $fell(ext0_irq_req) |-> $past(vector_ack_ext0 || wr_acc) ||
         $past(external_gate_input_zero) ||
         $past(external_gate_input_zero, 2);
   endproperty
   a_e0_fall: assert property (p_e0_fall)
      else $error("external flag dropped without cause");
   property p_irq_rise;
      $rose(irq) |-> $past(wr_acc) || reqs;
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt raised without event");
   property p_irq_fall;
      $fell(irq) |-> $past(wr_acc);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt dropped without write");
   c_irq: cover property ($rose(irq));
   c_pulse: cover property (timer1_overflow_pulse);
   c_err: cover property (pslverr);
endmodule : dtm_chk

bind dtm_dual_timer dtm_chk dtm_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .external_gate_input_zero(external_gate_input_zero),
   .vector_ack_timer0(vector_ack_timer0),
   .vector_ack_timer1(vector_ack_timer1),
   .vector_ack_ext0(vector_ack_ext0), .timer0_irq_req(timer0_irq_req),
   .timer1_irq_req(timer1_irq_req), .ext0_irq_req(ext0_irq_req),
   .ext1_irq_req(ext1_irq_req),
   .timer1_overflow_pulse(timer1_overflow_pulse), .irq(irq));

// ---- dv/dtm_dual_timer_tb.sv ----
// Purpose: Self-checking bench for the dual timer.
// Assumes: Zero-wait APB; pins driven just after rising edges.
// Notes: Counters are preloaded near wrap so runs stay short.
`timescale 1ns/100ps
module dtm_dual_timer_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, t0_req, t1_req, e0_req, e1_req, t1_pulse, irq;
   logic [1:0] cnt = 2'h3;
   logic [1:0] gin = 2'h3;
   logic [3:0] ack = 4'h0;
   logic [31:0] rd;
   int failures = 0;
   int samples_checked = 0;
   int pulses = 0;
   int cycles = 0;
   always #2 pclk = ~pclk;
   dtm_dual_timer dtm_dual_timer_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_input_pin_zero(cnt[0]),
      .count_input_pin_one(cnt[1]), .external_gate_input_zero(gin[0]),
      .external_gate_input_one(gin[1]), .vector_ack_timer0(ack[0]),
      .vector_ack_timer1(ack[1]), .vector_ack_ext0(ack[2]),
      .vector_ack_ext1(ack[3]), .timer0_irq_req(t0_req),
      .timer1_irq_req(t1_req), .ext0_irq_req(e0_req),
      .ext1_irq_req(e1_req), .timer1_overflow_pulse(t1_pulse),
      .irq(irq));
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Read data is taken at the access edge, where the slave answers.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk
   // Each level is held three cycles so the sampler cannot miss it.
   task automatic fall(input int n, input int c);
      repeat (n) begin
         @(posedge pclk);
         cnt[c] <= 1'b0;
         repeat (3) @(posedge pclk);
         cnt[c] <= 1'b1;
         repeat (3) @(posedge pclk);
      end
   endtask : fall
   task automatic vec(input int i);
      @(posedge pclk);
      ack[i] <= 1'b1;
      @(posedge pclk);
      ack[i] <= 1'b0;
      @(negedge pclk);
   endtask : vec
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (t1_pulse === 1'b1) pulses <= pulses + 1;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      int p0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a <= 32; a += 4) rchk(8'(a), 32'h0);
      wr(8'h24, 32'hff);
      rchk(8'h24, 32'h0);
      @(negedge pclk);
      chk(32'(pslverr), 32'h1);
      for (int t = 0; t < 2; t++) begin
         wr(8'h0c + 8'(t * 8), 32'hfe);
         wr(8'h08 + 8'(t * 8), 32'hfe);
         wr(8'h04, 32'h2 << (4 * t));
         wr(8'h18, 32'h1 << t);
         wr(8'h00, 32'h10 << (2 * t));
         repeat (12) @(posedge pclk);
         rchk(8'h00, 32'h30 << (2 * t));
         chk(32'(t ? t1_req : t0_req), 32'h1);
         rchk(8'h0c + 8'(t * 8), 32'hfe);
         wr(8'h00, 32'h20 << (2 * t));
         xfer(1'b0, 8'h08 + 8'(t * 8), 32'h0);
         chk(rd | 32'h1, 32'hff);
         vec(t);
         chk(32'(t ? t1_req : t0_req), 32'h0);
         wr(8'h20, 32'h1 << t);
         @(negedge pclk);
         chk(32'(irq), 32'h1);
         wr(8'h1c, 32'h1 << t);
         @(negedge pclk);
         chk(32'(irq), 32'h0);
         wr(8'h20, 32'h0);
      end
      wr(8'h00, 32'h0);
      wr(8'h08, 32'hfe);
      wr(8'h0c, 32'h0);
      wr(8'h04, 32'h05);
      wr(8'h00, 32'h10);
      fall(3, 0);
      rchk(8'h08, 32'h01);
      rchk(8'h0c, 32'h01);
      gin[0] <= 1'b0;
      wr(8'h04, 32'h0d);
      fall(2, 0);
      rchk(8'h08, 32'h01);
      rchk(8'h00, 32'h12);
      gin[0] <= 1'b1;
      fall(1, 0);
      rchk(8'h08, 32'h02);
      wr(8'h00, 32'h01);
      gin[0] <= 1'b0;
      repeat (3) @(posedge pclk);
      rchk(8'h00, 32'h03);
      gin[0] <= 1'b1;
      vec(2);
      chk(32'(e0_req), 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h18, 32'h3);
      wr(8'h10, 32'hff);
      wr(8'h14, 32'hff);
      wr(8'h0c, 32'hfe);
      p0 = pulses;
      wr(8'h04, 32'h13);
      repeat (8) @(posedge pclk);
      chk(32'(pulses > p0), 32'h1);
      rchk(8'h00, 32'h0);
      wr(8'h00, 32'h40);
      repeat (8) @(posedge pclk);
      rchk(8'h00, 32'hc0);
      chk(32'(t1_req), 32'h1);
      wr(8'h04, 32'h37);
      wr(8'h10, 32'h5a);
      wr(8'h08, 32'hfe);
      wr(8'h00, 32'h10);
      fall(2, 0);
      rchk(8'h10, 32'h5a);
      rchk(8'h08, 32'h00);
      rchk(8'h00, 32'h30);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'hd0);
      wr(8'h18, 32'h4);
      wr(8'h08, 32'h1e);
      wr(8'h0c, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h10);
      // The run lasts 43 edges, so divide-by-4 gives 10 or 11 steps.
      repeat (40) @(posedge pclk);
      wr(8'h00, 32'h0);
      xfer(1'b0, 8'h08, 32'h0);
      chk(32'(rd == 32'h8 || rd == 32'h9), 32'h1);
      rchk(8'h0c, 32'h01);
      wr(8'h00, 32'h44);
      fall(2, 1);
      gin[1] <= 1'b0;
      fall(1, 1);
      rchk(8'h10, 32'h02);
      rchk(8'h00, 32'h4c);
      chk(32'(e1_req), 32'h1);
      vec(3);
      chk(32'(e1_req), 32'h0);
      gin[1] <= 1'b1;
      tally_and_finish();
   end
endmodule : dtm_dual_timer_tb
